// [src/spp_pkg.sv]
// Summary of operation
// - master or slave, rates up to half clock
// - finished byte moves into read buffer
// - no transmit load while transfer runs
// - shift clock driven as master, input as slave
// - master drives out-line, slave drives in-line
// - master makes exactly eight clocks per byte
// - slave active only while select low
// - master select pin free unless configured
// - shifting out and in forms one ring
// - msb first, or lsb first when set
// - auto select only as master, faults off
// - control bit 6 enables the port
// - control bit 4 selects master role
// - control bit 3 sets clock idle level
// - control bit 2 picks sampling edge
// - only one master on the bus
// - master selects one slave at once
// - rate field divides by 2 to 16
// - complete flag set, blocks data writes
// - fault detect makes select a fault input
// - collision flag sticky until software clears
package spp_pkg;
    localparam logic [7:0] SPP_CTRL_ADDR = 8'hF3;
    localparam logic [7:0] SPP_STAT_ADDR = 8'hF4;
    localparam logic [7:0] SPP_DATA_ADDR = 8'hF5;
    localparam logic [7:0] SPP_CTRL_RST = 8'h00;
    localparam int SPP_SELECT_OUTPUT_AUTO_BIT = 7;
    localparam int SPP_EN_BIT = 6;
    localparam int SPP_LSB_BIT = 5;
    localparam int SPP_ROLE_MASTER_BIT = 4;
    localparam int SPP_CLOCK_IDLE_LEVEL_BIT = 3;
    localparam int SPP_CLOCK_SAMPLE_EDGE_BIT = 2;
    localparam int SPP_TCF_BIT = 7;
    localparam int SPP_WRITE_COLLISION_FLAG_BIT = 6;
    localparam int SPP_MULTI_MASTER_FAULT_FLAG_BIT = 4;
    localparam int SPP_FDD_BIT = 3;
    localparam logic [3:0] SPP_LAST_EDGE = 4'hF;
    localparam logic [3:0] SPP_LAST_BIT = 4'h7;
    localparam int SPP_SYS_NS = 10;
    localparam int SPP_LINK_NS = 160;
    localparam int SPP_LINK_HALF = SPP_LINK_NS / (2 * SPP_SYS_NS);

    function automatic logic spp_out_bit(input logic [7:0] d,
                                         input logic lsb);
        return lsb ? d[0] : d[7];
    endfunction

    function automatic logic [7:0] spp_shift(input logic [7:0] d,
                                             input logic b,
                                             input logic lsb);
        return lsb ? {b, d[7:1]} : {d[6:0], b};
    endfunction
endpackage

// [src/spp_link_if.sv]
`timescale 1ns/1ps
interface spp_link_if;
    logic dev_sclk_o, dev_sclk_oe, far_sclk_o, far_sclk_oe;
    logic dev_mosi_o, dev_mosi_oe, far_mosi_o, far_mosi_oe;
    logic dev_miso_o, dev_miso_oe, far_miso_o, far_miso_oe;
    logic dev_ss_o, dev_ss_oe, far_ss_o, far_ss_oe;
    logic sclk, mosi, miso, ss;

    // undriven lines settle low, select is pulled high
    assign sclk = dev_sclk_oe ? dev_sclk_o : (far_sclk_oe & far_sclk_o);
    assign mosi = dev_mosi_oe ? dev_mosi_o : (far_mosi_oe & far_mosi_o);
    assign miso = dev_miso_oe ? dev_miso_o : (far_miso_oe & far_miso_o);
    assign ss = dev_ss_oe ? dev_ss_o : (far_ss_oe ? far_ss_o : 1'b1);

    modport dev (
        output dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe,
        output dev_miso_o, dev_miso_oe, dev_ss_o, dev_ss_oe,
        input sclk, mosi, miso, ss
    );
    modport far (
        output far_sclk_o, far_sclk_oe, far_mosi_o, far_mosi_oe,
        output far_miso_o, far_miso_oe, far_ss_o, far_ss_oe,
        input sclk, mosi, miso, ss
    );
endinterface

// [src/spp_port.sv]
`timescale 1ns/1ps
module spp_port import spp_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    spp_link_if.dev link
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic tcf;
        logic write_collision_flag;
        logic multi_master_fault_flag;
        logic fdd;
        logic [7:0] sh;
        logic [7:0] rbuf;
        logic [7:0] rdata;
        logic busy;
        logic [3:0] edges;
        logic [3:0] bits;
        logic [3:0] div;
        logic sclk;
        logic dout;
        logic [2:0] sclk_s;
        logic [1:0] ss_s;
        logic [1:0] din_s;
    } spp_dev_t;

    spp_dev_t r;
    spp_dev_t next_r;

    logic en, mst, lsb, clock_idle_level, clock_sample_edge, sel, ev, lead, done, act;
    logic [3:0] half;
    logic [7:0] shv;

    assign en = r.ctrl[SPP_EN_BIT];
    assign mst = r.ctrl[SPP_ROLE_MASTER_BIT];
    assign lsb = r.ctrl[SPP_LSB_BIT];
    assign clock_idle_level = r.ctrl[SPP_CLOCK_IDLE_LEVEL_BIT];
    assign clock_sample_edge = r.ctrl[SPP_CLOCK_SAMPLE_EDGE_BIT];
    // divide by 2,4,8,16: each clock half lasts 1,2,4,8 cycles
    assign half = 4'(1 << r.ctrl[1:0]);
    assign sel = en & ~mst & ~r.ss_s[1];
    assign act = mst ? r.busy : (r.bits != 4'h0);

    always_comb begin
        next_r = r;
        ev = 1'b0;
        lead = 1'b0;
        done = 1'b0;
        shv = r.sh;
        next_r.rdata = 8'h00;
        next_r.sclk_s = {r.sclk_s[1:0], link.sclk};
        next_r.ss_s = {r.ss_s[0], link.ss};
        next_r.din_s = {r.din_s[0], mst ? link.miso : link.mosi};

        if (i_rd) begin
            case (i_addr)
                SPP_CTRL_ADDR: next_r.rdata = r.ctrl;
                SPP_STAT_ADDR: next_r.rdata = {r.tcf, r.write_collision_flag, 1'b0,
                                               r.multi_master_fault_flag, r.fdd, 3'b000};
                SPP_DATA_ADDR: next_r.rdata = r.rbuf;
                default: next_r.rdata = 8'h00;
            endcase
        end

        if (i_wr && i_addr == SPP_CTRL_ADDR) begin
            next_r.ctrl = i_wdata;
        end
        // writing a 0 clears a flag; a hardware set below wins
        if (i_wr && i_addr == SPP_STAT_ADDR) begin
            next_r.tcf = r.tcf & i_wdata[SPP_TCF_BIT];
            next_r.write_collision_flag = r.write_collision_flag & i_wdata[SPP_WRITE_COLLISION_FLAG_BIT];
            next_r.multi_master_fault_flag = r.multi_master_fault_flag & i_wdata[SPP_MULTI_MASTER_FAULT_FLAG_BIT];
            next_r.fdd = i_wdata[SPP_FDD_BIT];
        end
        if (i_wr && i_addr == SPP_DATA_ADDR && en) begin
            if (act) begin
                next_r.write_collision_flag = 1'b1;
            end else if (!r.tcf) begin
                next_r.sh = i_wdata;
                if (mst) begin
                    next_r.busy = 1'b1;
                    next_r.edges = 4'h0;
                    next_r.div = half - 4'h1;
                    next_r.dout = spp_out_bit(i_wdata, lsb);
                end
            end
        end

        if (mst) begin
            if (r.busy) begin
                if (r.div == 4'h0) begin
                    ev = 1'b1;
                    lead = ~r.edges[0];
                    next_r.sclk = ~r.sclk;
                    next_r.div = half - 4'h1;
                    next_r.edges = r.edges + 4'h1;
                    if (r.edges == SPP_LAST_EDGE) begin
                        next_r.busy = 1'b0;
                        done = 1'b1;
                    end
                end else begin
                    next_r.div = r.div - 4'h1;
                end
            end else begin
                next_r.sclk = clock_idle_level;
            end
        end else begin
            // only a selected slave looks at the clock
            ev = sel & (r.sclk_s[1] != r.sclk_s[2]);
            lead = (r.sclk_s[1] != clock_idle_level);
            next_r.sclk = clock_idle_level;
            if (!sel) begin
                next_r.bits = 4'h0;
            end
            if (r.bits == 4'h0 && !ev) begin
                next_r.dout = spp_out_bit(r.sh, lsb);
            end
        end

        if (ev) begin
            if (lead ^ clock_sample_edge) begin
                shv = spp_shift(r.sh, r.din_s[1], lsb);
                next_r.sh = shv;
                next_r.bits = r.bits + 4'h1;
                if (!mst && r.bits == SPP_LAST_BIT) begin
                    next_r.bits = 4'h0;
                    done = 1'b1;
                end
            end else begin
                next_r.dout = spp_out_bit(r.sh, lsb);
            end
        end
        if (done) begin
            next_r.rbuf = shv;
            next_r.bits = 4'h0;
            next_r.tcf = 1'b1;
        end

        // low select on a faulting master drops it to slave
        if (en && mst && !r.fdd && !r.ss_s[1]) begin
            next_r.multi_master_fault_flag = 1'b1;
            next_r.ctrl[SPP_ROLE_MASTER_BIT] = 1'b0;
            next_r.busy = 1'b0;
            next_r.bits = 4'h0;
        end
        if (!en) begin
            next_r.busy = 1'b0;
            next_r.bits = 4'h0;
            next_r.sclk = clock_idle_level;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r <= '0;
            r.ctrl <= SPP_CTRL_RST;
            r.ss_s <= 2'b11;
        end else if (i_ce) begin
            r <= next_r;
        end
    end

    assign o_rdata = r.rdata;
    assign link.dev_sclk_o = r.sclk;
    assign link.dev_sclk_oe = en & mst;
    assign link.dev_mosi_o = r.dout;
    assign link.dev_mosi_oe = en & mst;
    assign link.dev_miso_o = r.dout;
    assign link.dev_miso_oe = sel;
    assign link.dev_ss_o = ~r.busy;
    // otherwise the select pin is left to general use
    assign link.dev_ss_oe = en & mst & r.fdd
                            & r.ctrl[SPP_SELECT_OUTPUT_AUTO_BIT];
endmodule

// [src/spp_far_master.sv]
`timescale 1ns/1ps
module spp_far_master import spp_pkg::*; #(
    parameter logic [7:0] HALF = 8'(SPP_LINK_HALF)
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_start,
    input wire logic [7:0] i_tx,
    input wire logic i_clock_idle_level,
    input wire logic i_clock_sample_edge,
    input wire logic i_lsb,
    output logic [7:0] o_rx,
    output logic o_done,
    output logic o_busy,
    spp_link_if.far link
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [7:0] div;
        logic [3:0] edges;
        logic [7:0] sh;
        logic [7:0] rx;
        logic sclk;
        logic dout;
        logic [1:0] miso_s;
    } spp_far_t;

    spp_far_t r;
    spp_far_t next_r;

    logic lead;

    always_comb begin
        next_r = r;
        lead = ~r.edges[0];
        next_r.done = 1'b0;
        next_r.miso_s = {r.miso_s[0], link.miso};
        if (!r.busy) begin
            next_r.sclk = i_clock_idle_level;
            if (i_start) begin
                next_r.busy = 1'b1;
                next_r.sh = i_tx;
                next_r.edges = 4'h0;
                next_r.div = HALF - 8'h01;
                next_r.dout = spp_out_bit(i_tx, i_lsb);
            end
        end else if (r.div != 8'h00) begin
            next_r.div = r.div - 8'h01;
        end else begin
            next_r.sclk = ~r.sclk;
            next_r.div = HALF - 8'h01;
            next_r.edges = r.edges + 4'h1;
            if (lead ^ i_clock_sample_edge) begin
                next_r.sh = spp_shift(r.sh, r.miso_s[1], i_lsb);
            end else begin
                next_r.dout = spp_out_bit(r.sh, i_lsb);
            end
            if (r.edges == SPP_LAST_EDGE) begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
                next_r.rx = (lead ^ i_clock_sample_edge) ?
                            spp_shift(r.sh, r.miso_s[1], i_lsb) : r.sh;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r <= '0;
        end else if (i_ce) begin
            r <= next_r;
        end
    end

    assign o_rx = r.rx;
    assign o_done = r.done;
    assign o_busy = r.busy;
    // master with clock, out-line and select always enabled, driving one select line
    assign link.far_sclk_o = r.sclk;
    assign link.far_sclk_oe = 1'b1;
    assign link.far_mosi_o = r.dout;
    assign link.far_mosi_oe = 1'b1;
    assign link.far_miso_o = 1'b0;
    assign link.far_miso_oe = 1'b0;
    // select stays low one cycle past the last edge, so a slave whose
    // select and clock syncs have equal depth still sees that edge
    assign link.far_ss_o = ~(r.busy | r.done);
    assign link.far_ss_oe = 1'b1;
endmodule

// [verif/spp_link_monitor.sv]
`timescale 1ns/1ps
module spp_link_monitor (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic dev_sclk_o,
    input wire logic dev_sclk_oe,
    input wire logic dev_mosi_oe,
    input wire logic dev_miso_oe,
    input wire logic dev_ss_o,
    input wire logic dev_ss_oe,
    input wire logic ss
);
    logic sclk_q;
    logic ss_q;
    logic [4:0] edges;
    // count every clock toggle since the last select fall
    always_ff @(posedge i_clk) begin
        sclk_q <= dev_sclk_o;
        ss_q <= dev_ss_o;
        if (i_rst || (ss_q && !dev_ss_o)) begin
            edges <= 5'h00;
        end else if (dev_sclk_o != sclk_q) begin
            edges <= edges + 5'h01;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence frame_start;
        $fell(dev_ss_o) && dev_ss_oe;
    endsequence
    sequence frame_end;
        $rose(dev_ss_o) && dev_ss_oe;
    endsequence
    a_eight_clocks: assert property (frame_end |=> edges == 5'h10)
        else $error("clock edge count per byte wrong");
    // tests run the master at rate code 11 only, half period 8
    a_rate_first_edge: assert property (
        frame_start |-> dev_sclk_oe ##1 $stable(dev_sclk_o)[*6])
        else $error("first master clock edge too early");
    a_ss_low_clocking: assert property (
        dev_ss_oe && $changed(dev_sclk_o) |-> !dev_ss_o || !$past(dev_ss_o))
        else $error("master clock moved while select idle");
    a_master_pins: assert property (
        dev_sclk_oe |-> dev_mosi_oe && !dev_miso_oe)
        else $error("master pin drive wrong");
    a_slave_pins: assert property (
        dev_miso_oe |-> !dev_sclk_oe && !dev_ss_oe)
        else $error("slave drives master pins");
    a_ss_only_master: assert property (dev_ss_oe |-> dev_sclk_oe)
        else $error("select driven outside master mode");
    a_slave_deselect: assert property (ss[*4] |-> !dev_miso_oe)
        else $error("deselected slave drives miso");
    a_miso_on_select: assert property (
        $rose(dev_miso_oe) |-> !ss && !$past(ss))
        else $error("miso drive without select");
endmodule

// [verif/tb_spp_port.sv]
`timescale 1ns/1ps
module tb_spp_port import spp_pkg::*; ;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic start = 1'b0;
    logic clock_idle_level = 1'b0;
    logic clock_sample_edge = 1'b0;
    logic lsb = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] tx = 8'h00;
    logic [7:0] rdata, rx, d, t;
    logic done, busy;
    int err_total = 0;
    int checks = 0;
    spp_link_if link ();
    spp_port i_spp_port (.i_clk(clk), .i_rst(rst), .i_ce(1'b1),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .link(link.dev));
    spp_far_master i_spp_far_master (.i_clk(clk), .i_rst(rst),
        .i_ce(1'b1), .i_start(start), .i_tx(tx), .i_clock_idle_level(clock_idle_level),
        .i_clock_sample_edge(clock_sample_edge), .i_lsb(lsb), .o_rx(rx), .o_done(done),
        .o_busy(busy), .link(link.far));
    spp_link_monitor i_spp_link_monitor (.i_clk(clk), .i_rst(rst),
        .dev_sclk_o(link.dev_sclk_o), .dev_sclk_oe(link.dev_sclk_oe),
        .dev_mosi_oe(link.dev_mosi_oe), .dev_miso_oe(link.dev_miso_oe),
        .dev_ss_o(link.dev_ss_o), .dev_ss_oe(link.dev_ss_oe),
        .ss(link.ss));
    initial forever #5 clk = ~clk;
    function automatic logic [7:0] ctrl_word(input logic [2:0] m);
        return 8'h40 | {2'b00, m[2], 1'b0, m[0], m[1], 2'b00};
    endfunction
    task automatic end_sim();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    // sel 1 waits for the select line to rise, 0 for the far done pulse
    task automatic wait_high(input logic sel);
        int n;
        n = 0;
        while ((sel ? link.dev_ss_o : done) !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({7'h00, n < 400}, 8'h01);
    endtask
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h3A01));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd_chk(SPP_CTRL_ADDR, SPP_CTRL_RST);
        rd_chk(SPP_STAT_ADDR, 8'h00);
        wr_reg(8'h10, 8'hFF);
        rd_chk(8'h10, 8'h00);
        rd_chk(SPP_CTRL_ADDR, 8'h00);
        for (int m = 0; m < 8; m++) begin
            d = (m == 0) ? 8'h81 : 8'($urandom);
            t = (m == 0) ? 8'h7E : 8'($urandom);
            // far mode changes while deselected, device must ignore it
            @(posedge clk);
            clock_idle_level <= m[0];
            clock_sample_edge <= m[1];
            lsb <= m[2];
            wr_reg(SPP_CTRL_ADDR, ctrl_word(3'(m)));
            wr_reg(SPP_DATA_ADDR, d);
            @(posedge clk);
            start <= 1'b1;
            tx <= t;
            @(posedge clk);
            start <= 1'b0;
            wait_high(1'b0);
            repeat (8) @(posedge clk);
            chk(rx, d);
            rd_chk(SPP_DATA_ADDR, t);
            rd_chk(SPP_STAT_ADDR, 8'h80);
            wr_reg(SPP_STAT_ADDR, 8'h00);
        end
        wr_reg(SPP_CTRL_ADDR, 8'h00);
        wr_reg(SPP_STAT_ADDR, 8'h08);
        wr_reg(SPP_CTRL_ADDR, 8'hF3);
        d = 8'($urandom);
        wr_reg(SPP_DATA_ADDR, d);
        wr_reg(SPP_DATA_ADDR, ~d);
        #1;
        chk({7'h00, link.mosi}, {7'h00, d[0]});
        chk({7'h00, link.ss}, 8'h00);
        wait_high(1'b1);
        rd_chk(SPP_STAT_ADDR, 8'hC8);
        rd_chk(SPP_DATA_ADDR, 8'h00);
        wr_reg(SPP_DATA_ADDR, d);
        repeat (40) @(posedge clk);
        chk({7'h00, link.dev_ss_o}, 8'h01);
        wr_reg(SPP_STAT_ADDR, 8'h48);
        rd_chk(SPP_STAT_ADDR, 8'h48);
        wr_reg(SPP_STAT_ADDR, 8'h08);
        rd_chk(SPP_STAT_ADDR, 8'h08);
        end_sim();
    end
endmodule
